// ---- verilog/twru_defs.vh ----
// Constants for the triple watchdog reset unit: register offsets, fields, resets, timing.
// Included by the watchdog unit and its windowed watchdog counter module.
`ifndef TWRU_DEFS_VH
`define TWRU_DEFS_VH

// Register byte offsets (one aligned word each)
`define TWRU_OFF_A_CTRL     8'h00
`define TWRU_OFF_A_PERIOD   8'h04
`define TWRU_OFF_A_WINDOW   8'h08
`define TWRU_OFF_A_COUNT    8'h0c
`define TWRU_OFF_B_CTRL     8'h10
`define TWRU_OFF_B_PERIOD   8'h14
`define TWRU_OFF_B_WINDOW   8'h18
`define TWRU_OFF_B_COUNT    8'h1c
`define TWRU_OFF_AON_CTRL   8'h20
`define TWRU_OFF_AON_COUNT  8'h24
`define TWRU_OFF_RESTART    8'h28
`define TWRU_OFF_CAUSE      8'h2c
`define TWRU_OFF_STATUS     8'h30
`define TWRU_OFF_MASK       8'h34

// Windowed control fields
`define TWRU_CTL_EN         0
`define TWRU_CTL_WIN        1
`define TWRU_CTL_POR        2
`define TWRU_CTL_SRC_LO     3
`define TWRU_CTL_SRC_HI     4
`define TWRU_CTL_PRE_LO     8
`define TWRU_CTL_PRE_HI     15

// Always-on control fields
`define TWRU_AON_EN         0
`define TWRU_AON_POR        1
`define TWRU_AON_SEL_LO     4
`define TWRU_AON_SEL_HI     7

// Clock source encodings
`define TWRU_SRC_SYS        2'h0
`define TWRU_SRC_RTC        2'h1
`define TWRU_SRC_PMU        2'h2

// Restart key values written to the restart register
`define TWRU_KEY_A          32'h0000a5a1
`define TWRU_KEY_B          32'h0000a5b2
`define TWRU_KEY_AON        32'h0000a5c3

// Status / cause bits
`define TWRU_BIT_A          0
`define TWRU_BIT_B          1
`define TWRU_BIT_AON        2

// Reset values
`define TWRU_RST_CTRL       32'h00000000
`define TWRU_RST_PERIOD     32'hffffffff
`define TWRU_RST_WINDOW     32'h00000000
`define TWRU_RST_AON_CTRL   32'h000000f0

// Always-on timing: 32768 Hz tick, longest timeout 8 s = 2^18 ticks
`define TWRU_AON_TICK_HZ    32768
`define TWRU_AON_MAX_S      8
`define TWRU_AON_MAX_TICKS  (`TWRU_AON_TICK_HZ * `TWRU_AON_MAX_S)
`define TWRU_AON_CNT_W      19

`endif

// ---- verilog/twru_window_wdog.v ----
// One windowed watchdog: prescaler and 32-bit up counter with window check.
// Assumes synchronised one-cycle tick inputs from the parent on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "twru_defs.vh"
module twru_window_wdog
#(
   parameter CNT_W = 32,
   parameter PRE_W = 8
)
(
   // Clock and reset
   input  wire             ref_clk_i,
   input  wire             rst_b_i,
   // Configuration
   input  wire             enable_i,
   input  wire             window_en_i,
   input  wire [1:0]       src_sel_i,
   input  wire [PRE_W-1:0] prescale_i,
   input  wire [CNT_W-1:0] period_i,
   input  wire [CNT_W-1:0] window_i,
   // Count sources
   input  wire             sys_tick_i,
   input  wire             rtc_tick_i,
   input  wire             pmu_tick_i,
   // Restart and result
   input  wire             restart_i,
   output reg  [CNT_W-1:0] count_o,
   output reg              expire_o
);
   reg  [PRE_W-1:0] pre;
   reg              src_tick;
   wire             early;
   wire             cnt_tick;

   always @*
   begin
      case (src_sel_i)
         `TWRU_SRC_SYS: src_tick = sys_tick_i;
         `TWRU_SRC_RTC: src_tick = rtc_tick_i;
         `TWRU_SRC_PMU: src_tick = pmu_tick_i;
         default:       src_tick = 1'b0;
      endcase
   end

   assign cnt_tick = src_tick && (pre == prescale_i);
   // Restart before the window opens counts as a missed restart
   assign early = window_en_i && (count_o < window_i);

   always @(posedge ref_clk_i)
   begin
      if (!rst_b_i || !enable_i)
      begin
         pre      <= {PRE_W{1'b0}};
         count_o  <= {CNT_W{1'b0}};
         expire_o <= 1'b0;
      end
      else
      begin
         expire_o <= 1'b0;
         if (restart_i && early)
            expire_o <= 1'b1;
         else if (restart_i)
         begin
            pre     <= {PRE_W{1'b0}};
            count_o <= {CNT_W{1'b0}};
         end
         else if (src_tick)
         begin
            pre <= cnt_tick ? {PRE_W{1'b0}} : pre + 1'b1;
            if (cnt_tick)
            begin
               if (count_o >= period_i)
               begin
                  expire_o <= 1'b1;
                  count_o  <= {CNT_W{1'b0}};
               end
               else
                  count_o <= count_o + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/twru_unit.v ----
// Watchdog unit: two windowed watchdogs, one always-on watchdog, AHB-Lite slave.
// Assumes AHB-Lite single word transfers; rtc and pmu ticks arrive asynchronously;
// aon logic sits on an always-powered supply, modelled here on the same clock.
//
// Behaviour
// - Two independent windowed watchdogs, each with its own window mode enable.
// - Each counts a 32-bit counter through a prescaler; expiry requests reset unless in sleep.
// - Missing restart, or restart outside the window, is a timeout.
// - Timeout requests firmware system reset or power-on reset per configuration.
// - A reset request from watchdog a or b sets its cause flag, kept across system reset.
// - Windowed count clock: scaled system clock, rtc clock or pmu clock.
// - A separate third watchdog recovers from runaway code.
// - Always-on expiry sets its own cause flag, readable after a system reset.
// - Always-on watchdog keeps counting in retention and deepest sleep states.
// - Always-on timeout programmable up to 8 seconds, coarse steps.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "twru_defs.vh"
module twru_unit
#(
   parameter SYS_DIV = 16
)
(
   // Clock and resets
   input  wire        ref_clk_i,
   input  wire        rst_b_i,
   input  wire        por_b_i,
   // Asynchronous count sources
   input  wire        rtc_clk_i,
   input  wire        pmu_clk_i,
   // Power state
   input  wire        sleep_i,
   // AHB-Lite slave
   input  wire        hsel_i,
   input  wire [7:0]  haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // Reset requests and interrupt
   output reg         sys_rst_req_o,
   output reg         por_rst_req_o,
   output wire        irq_o
);
   reg [31:0] ctrl_a;
   reg [31:0] ctrl_b;
   reg [31:0] period_a;
   reg [31:0] period_b;
   reg [31:0] window_a;
   reg [31:0] window_b;
   reg [31:0] aon_ctrl;
   reg [2:0]  cause;
   reg [2:0]  status;
   reg [2:0]  mask;
   reg [31:0] rdata;
   reg        wr_pend;
   reg [7:0]  wr_addr;
   reg        rtc_s1;
   reg        rtc_s2;
   reg        rtc_s3;
   reg        pmu_s1;
   reg        pmu_s2;
   reg        pmu_s3;
   reg [7:0]  sys_div;
   reg [`TWRU_AON_CNT_W-1:0] aon_cnt;
   reg        aon_exp;
   reg [31:0] next_rdata;
   wire       rtc_tick;
   wire       pmu_tick;
   wire       sys_tick;
   wire [31:0] count_a;
   wire [31:0] count_b;
   wire       exp_a;
   wire       exp_b;
   wire       rst_a;
   wire       rst_b;
   wire       restart_a;
   wire       restart_b;
   wire       restart_aon;
   wire       rd_req;
   wire       wr_req;
   wire [`TWRU_AON_CNT_W-1:0] aon_limit;
   wire [`TWRU_AON_CNT_W-1:0] aon_one;
   wire [4:0] aon_shift;
   wire [2:0] events;
   wire [2:0] rst_events;

   // Bus: zero wait states, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata;
   assign rd_req = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   assign wr_req = hsel_i && hready_i && htrans_i[1] && hwrite_i;

   // Two-flop synchronisers, third flop only for the edge detect
   always @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         rtc_s1 <= 1'b0;
         rtc_s2 <= 1'b0;
         rtc_s3 <= 1'b0;
         pmu_s1 <= 1'b0;
         pmu_s2 <= 1'b0;
         pmu_s3 <= 1'b0;
      end
      else
      begin
         rtc_s1 <= rtc_clk_i;
         rtc_s2 <= rtc_s1;
         rtc_s3 <= rtc_s2;
         pmu_s1 <= pmu_clk_i;
         pmu_s2 <= pmu_s1;
         pmu_s3 <= pmu_s2;
      end
   end
   assign rtc_tick = rtc_s2 && !rtc_s3;
   assign pmu_tick = pmu_s2 && !pmu_s3;

   // Scaled system clock tick
   always @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         sys_div <= 8'h00;
      else if (sys_div == SYS_DIV - 1)
         sys_div <= 8'h00;
      else
         sys_div <= sys_div + 8'h01;
   end
   assign sys_tick = (sys_div == SYS_DIV - 1);

   // Restart writes carry a key so a stray store cannot feed a watchdog
   assign restart_a   = wr_pend && (wr_addr == `TWRU_OFF_RESTART)
                        && (hwdata_i == `TWRU_KEY_A);
   assign restart_b   = wr_pend && (wr_addr == `TWRU_OFF_RESTART)
                        && (hwdata_i == `TWRU_KEY_B);
   assign restart_aon = wr_pend && (wr_addr == `TWRU_OFF_RESTART)
                        && (hwdata_i == `TWRU_KEY_AON);

   // Two independent windowed watchdogs
   twru_window_wdog #(.CNT_W(32), .PRE_W(8)) u_wdog_a
   (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .enable_i    (ctrl_a[`TWRU_CTL_EN]),
      .window_en_i (ctrl_a[`TWRU_CTL_WIN]),
      .src_sel_i   (ctrl_a[`TWRU_CTL_SRC_HI:`TWRU_CTL_SRC_LO]),
      .prescale_i  (ctrl_a[`TWRU_CTL_PRE_HI:`TWRU_CTL_PRE_LO]),
      .period_i    (period_a),
      .window_i    (window_a),
      .sys_tick_i  (sys_tick),
      .rtc_tick_i  (rtc_tick),
      .pmu_tick_i  (pmu_tick),
      .restart_i   (restart_a),
      .count_o     (count_a),
      .expire_o    (exp_a)
   );

   twru_window_wdog #(.CNT_W(32), .PRE_W(8)) u_wdog_b
   (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .enable_i    (ctrl_b[`TWRU_CTL_EN]),
      .window_en_i (ctrl_b[`TWRU_CTL_WIN]),
      .src_sel_i   (ctrl_b[`TWRU_CTL_SRC_HI:`TWRU_CTL_SRC_LO]),
      .prescale_i  (ctrl_b[`TWRU_CTL_PRE_HI:`TWRU_CTL_PRE_LO]),
      .period_i    (period_b),
      .window_i    (window_b),
      .sys_tick_i  (sys_tick),
      .rtc_tick_i  (rtc_tick),
      .pmu_tick_i  (pmu_tick),
      .restart_i   (restart_b),
      .count_o     (count_b),
      .expire_o    (exp_b)
   );

   // Always-on watchdog: counts rtc ticks, limit 2^(sel+3) ticks, 8 s at sel 15
   // Shift is five bits wide so sel 15 plus 3 does not wrap
   assign aon_one   = {{(`TWRU_AON_CNT_W-1){1'b0}}, 1'b1};
   assign aon_shift = {1'b0, aon_ctrl[`TWRU_AON_SEL_HI:`TWRU_AON_SEL_LO]} + 5'h03;
   assign aon_limit = (aon_one << aon_shift) - aon_one;

   // Held at zero only by power-on reset or enable low; sleep does not stop it, system reset holds its rtc ticks
   always @(posedge ref_clk_i)
   begin
      if (!por_b_i || !aon_ctrl[`TWRU_AON_EN])
      begin
         aon_cnt <= {`TWRU_AON_CNT_W{1'b0}};
         aon_exp <= 1'b0;
      end
      else
      begin
         aon_exp <= 1'b0;
         if (restart_aon)
            aon_cnt <= {`TWRU_AON_CNT_W{1'b0}};
         else if (rtc_tick)
         begin
            if (aon_cnt >= aon_limit)
            begin
               aon_exp <= 1'b1;
               aon_cnt <= {`TWRU_AON_CNT_W{1'b0}};
            end
            else
               aon_cnt <= aon_cnt + 1'b1;
         end
      end
   end

   // Reset requests; windowed watchdog requests are masked in sleep, the aon one is not
   assign rst_a = exp_a && !sleep_i;
   assign rst_b = exp_b && !sleep_i;
   always @(posedge ref_clk_i)
   begin
      if (!por_b_i)
      begin
         sys_rst_req_o <= 1'b0;
         por_rst_req_o <= 1'b0;
      end
      else
      begin
         sys_rst_req_o <= (rst_a && !ctrl_a[`TWRU_CTL_POR]) ||
                          (rst_b && !ctrl_b[`TWRU_CTL_POR]) ||
                          (aon_exp && !aon_ctrl[`TWRU_AON_POR]);
         por_rst_req_o <= (rst_a && ctrl_a[`TWRU_CTL_POR]) ||
                          (rst_b && ctrl_b[`TWRU_CTL_POR]) ||
                          (aon_exp && aon_ctrl[`TWRU_AON_POR]);
      end
   end

   // Status sees every expiry; cause only those that reset the system
   assign events     = {aon_exp, exp_b, exp_a};
   assign rst_events = {aon_exp, rst_b, rst_a};

   // Cause flags survive system reset; cleared only by power-on or write-one
   always @(posedge ref_clk_i)
   begin
      if (!por_b_i)
         cause <= 3'h0;
      else if (wr_pend && wr_addr == `TWRU_OFF_CAUSE)
         cause <= (cause & ~hwdata_i[2:0]) | rst_events;
      else
         cause <= cause | rst_events;
   end

   // Registers, status and read data
   always @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         ctrl_a   <= `TWRU_RST_CTRL;
         ctrl_b   <= `TWRU_RST_CTRL;
         period_a <= `TWRU_RST_PERIOD;
         period_b <= `TWRU_RST_PERIOD;
         window_a <= `TWRU_RST_WINDOW;
         window_b <= `TWRU_RST_WINDOW;
         mask     <= 3'h0;
         status   <= 3'h0;
         wr_pend  <= 1'b0;
         wr_addr  <= 8'h00;
         rdata    <= 32'h00000000;
      end
      else
      begin
         wr_pend <= wr_req;
         wr_addr <= haddr_i;
         if (wr_pend)
         begin
            case (wr_addr)
               `TWRU_OFF_A_CTRL:   ctrl_a   <= hwdata_i;
               `TWRU_OFF_A_PERIOD: period_a <= hwdata_i;
               `TWRU_OFF_A_WINDOW: window_a <= hwdata_i;
               `TWRU_OFF_B_CTRL:   ctrl_b   <= hwdata_i;
               `TWRU_OFF_B_PERIOD: period_b <= hwdata_i;
               `TWRU_OFF_B_WINDOW: window_b <= hwdata_i;
               `TWRU_OFF_MASK:     mask     <= hwdata_i[2:0];
               default:            mask     <= mask;
            endcase
         end
         // A new event wins over the read that clears
         if (rd_req && haddr_i == `TWRU_OFF_STATUS)
            status <= events;
         else
            status <= status | events;
         rdata <= rd_req ? next_rdata : 32'h00000000;
      end
   end

   // Always-on control sits on the power-on reset domain
   always @(posedge ref_clk_i)
   begin
      if (!por_b_i)
         aon_ctrl <= `TWRU_RST_AON_CTRL;
      else if (wr_pend && wr_addr == `TWRU_OFF_AON_CTRL)
         aon_ctrl <= hwdata_i;
   end

   always @*
   begin
      case (haddr_i)
         `TWRU_OFF_A_CTRL:    next_rdata = ctrl_a;
         `TWRU_OFF_A_PERIOD:  next_rdata = period_a;
         `TWRU_OFF_A_WINDOW:  next_rdata = window_a;
         `TWRU_OFF_A_COUNT:   next_rdata = count_a;
         `TWRU_OFF_B_CTRL:    next_rdata = ctrl_b;
         `TWRU_OFF_B_PERIOD:  next_rdata = period_b;
         `TWRU_OFF_B_WINDOW:  next_rdata = window_b;
         `TWRU_OFF_B_COUNT:   next_rdata = count_b;
         `TWRU_OFF_AON_CTRL:  next_rdata = aon_ctrl;
         `TWRU_OFF_AON_COUNT: next_rdata = {{(32-`TWRU_AON_CNT_W){1'b0}}, aon_cnt};
         `TWRU_OFF_CAUSE:     next_rdata = {29'h0, cause};
         `TWRU_OFF_STATUS:    next_rdata = {29'h0, status};
         `TWRU_OFF_MASK:      next_rdata = {29'h0, mask};
         default:             next_rdata = 32'h00000000;
      endcase
   end

   assign irq_o = |(status & mask);
endmodule
`default_nettype wire

// ---- bench/twru_chk.sv ----
// Checker for the watchdog unit: bus answers, reset requests and interrupt.
// Sees only the top module ports; bound to every twru_unit instance.
`timescale 1ns/1ps
`default_nettype none
module twru_chk (
   // Clock and resets
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic        por_b_i,
   // Bus
   input wire logic        hsel_i,
   input wire logic [7:0]  haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   // Results
   input wire logic        sys_rst_req_o,
   input wire logic        por_rst_req_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   logic rd_dp;
   always @(posedge ref_clk_i)
   begin
      rd_dp <= rst_b_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   end
   sequence s_take;
      hsel_i && hready_i && htrans_i[1];
   endsequence
   sequence s_mask_off;
      s_take ##0 (hwrite_i && haddr_i == 8'h34) ##1 hwdata_i == 32'h0;
   endsequence
   property p_ready;
      disable iff (!rst_b_i) hreadyout_o && !hresp_o;
   endproperty
   property p_idle;
      disable iff (!rst_b_i) !rd_dp |-> hrdata_o == 32'h0;
   endproperty
   property p_unmapped;
      disable iff (!rst_b_i) s_take ##0 (!hwrite_i && haddr_i > 8'h34) |=> hrdata_o == 32'h0;
   endproperty
   // Requests must not leak out while the system is held in reset
   property p_quiet;
      disable iff (!por_b_i) !rst_b_i |=> !sys_rst_req_o && !por_rst_req_o;
   endproperty
   property p_sys_pulse;
      disable iff (!rst_b_i) $rose(sys_rst_req_o) |=> !sys_rst_req_o;
   endproperty
   property p_por_pulse;
      disable iff (!rst_b_i) por_rst_req_o |=> !por_rst_req_o;
   endproperty
   property p_one_kind;
      disable iff (!rst_b_i) !(sys_rst_req_o && por_rst_req_o);
   endproperty
   property p_mask;
      disable iff (!rst_b_i) s_mask_off |=> !irq_o;
   endproperty
   a_ready: assert property (p_ready)
      else $error("bus answer not ready or not okay");
   a_idle: assert property (p_idle)
      else $error("read data not zero outside a read");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_quiet: assert property (p_quiet)
      else $error("reset request during reset");
   a_sys_pulse: assert property (p_sys_pulse)
      else $error("system request longer than one cycle");
   a_por_pulse: assert property (p_por_pulse)
      else $error("power-on request longer than one cycle");
   a_one_kind: assert property (p_one_kind)
      else $error("both reset kinds at once");
   a_mask: assert property (p_mask)
      else $error("interrupt high with all masked");
endmodule
bind twru_unit twru_chk u_chk (.ref_clk_i, .rst_b_i, .por_b_i, .hsel_i, .haddr_i, .htrans_i,
   .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .sys_rst_req_o,
   .por_rst_req_o, .irq_o);
`default_nettype wire

// ---- bench/twru_rst_model.sv ----
// Model of the system reset controller answering the unit's requests.
// Assumes one clock; init_b_i is the board power-on reset.
`timescale 1ns/1ps
`default_nettype none
module twru_rst_model
#(
   parameter [3:0] HOLD = 4'h4
)
(
   // Clock and board reset
   input  wire logic clk_i,
   input  wire logic init_b_i,
   // Requests in, resets out
   input  wire logic sys_req_i,
   input  wire logic por_req_i,
   output wire logic rst_b_o,
   output wire logic por_b_o
);
   logic [3:0] cnt;
   logic       por;
   always @(posedge clk_i)
   begin
      if (!init_b_i)
      begin
         cnt <= HOLD;
         por <= 1'b1;
      end
      else if (sys_req_i || por_req_i)
      begin
         cnt <= HOLD;
         por <= por_req_i;
      end
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   // A system reset leaves the power-on domain alone, so cause flags survive
   assign rst_b_o = (cnt == 4'h0);
   assign por_b_o = (cnt == 4'h0) || !por;
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the watchdog unit with a reset controller model.
// Assumes twru_defs.vh on the include path; system clock divided by 2.
`timescale 1ns/1ps
`default_nettype none
`include "twru_defs.vh"
`define CHK(nm, e, g) \
   begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic        clk, rtc, pmu, init_b, sleep, hsel, hwrite, rd_dp;
   logic [7:0]  haddr, b, a_v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, lfsr, e_v;
   wire  [31:0] hrdata;
   wire         hrdy, hresp, sreq, preq, irq, rst_b, por_b;
   int          mismatches, n_tests, nreq, n0, k;
   logic [31:0] q[$];
   logic [7:0]  qa[$];
   twru_unit #(.SYS_DIV(2)) dut (.ref_clk_i(clk), .rst_b_i(rst_b), .por_b_i(por_b),
      .rtc_clk_i(rtc), .pmu_clk_i(pmu), .sleep_i(sleep), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .sys_rst_req_o(sreq), .por_rst_req_o(preq), .irq_o(irq));
   twru_rst_model rc (.clk_i(clk), .init_b_i(init_b), .sys_req_i(sreq), .por_req_i(preq),
      .rst_b_o(rst_b), .por_b_o(por_b));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      rtc = 1'b0;
      forever #18.3 rtc = ~rtc;
   end
   initial
   begin
      pmu = 1'b0;
      forever #13.1 pmu = ~pmu;
   end
   function automatic logic [31:0] nx(input logic [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic conclude;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (!hrdy);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (!hrdy);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      qa.push_back(a);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      for (k = 0; k < 100 && !(rst_b && por_b); k++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   // Expiry of the kind asked for, within lim cycles
   task automatic wreq(input logic p, input int lim);
      for (k = 0; k < lim && !(sreq || preq); k++)
      begin
         @(posedge clk);
         #1;
      end
      `CHK("reset request", {!p, p}, {sreq, preq})
      settle();
   endtask
   always @(posedge clk)
   begin
      if (rd_dp)
      begin
         e_v = q.pop_front();
         a_v = qa.pop_front();
         `CHK($sformatf("reg %h", a_v), e_v, hrdata)
      end
      nreq <= nreq + int'(sreq | preq);
      rd_dp <= hsel && htrans[1] && !hwrite;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata, sleep, init_b, rd_dp} = '0;
      hsize = 3'h2;
      lfsr = 32'h03cb;
      nreq = 0;
      repeat (12) @(posedge clk);
      init_b <= 1'b1;
      settle();
      rd(8'h00, 32'h0);
      rd(8'h04, 32'hffffffff);
      rd(8'h18, 32'h0);
      rd(8'h20, 32'hf0);
      lfsr = nx(lfsr);
      wr(8'h3c, lfsr);
      rd(8'h3c, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         b = (i == 1) ? 8'h10 : 8'h00;
         wr(b + 8'h04, 32'h8);
         wr(b, {27'h0, i[1:0], 3'h1});
         wreq(1'b0, 300);
         rd(8'h2c, (i == 1) ? 32'h2 : 32'h1);
         wr(8'h2c, 32'h7);
      end
      // Restarts at random spacing keep a short period alive
      wr(8'h04, 32'h4);
      wr(8'h00, 32'h1);
      n0 = nreq;
      repeat (20)
      begin
         wr(8'h28, `TWRU_KEY_A);
         lfsr = nx(lfsr);
         repeat (lfsr[1:0]) @(posedge clk);
      end
      #1;
      `CHK("restarted", n0, nreq)
      wreq(1'b0, 100);
      wr(8'h04, 32'h10);
      wr(8'h08, 32'hc);
      wr(8'h00, 32'h3);
      wr(8'h28, `TWRU_KEY_A);
      wreq(1'b0, 10);
      wr(8'h2c, 32'h7);
      sleep <= 1'b1;
      wr(8'h20, 32'h3);
      wreq(1'b1, 400);
      rd(8'h2c, 32'h0);
      wr(8'h20, 32'h1);
      wreq(1'b0, 400);
      rd(8'h2c, 32'h4);
      wr(8'h20, 32'h0);
      // Sleep holds back the windowed reset, so only the event remains
      n0 = nreq;
      wr(8'h34, 32'h1);
      wr(8'h04, 32'h4);
      wr(8'h00, 32'h1);
      for (k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk);
      #1;
      `CHK("irq", 1'b1, irq)
      `CHK("sleep", n0, nreq)
      wr(8'h00, 32'h0);
      wr(8'h34, 32'h0);
      #1;
      `CHK("irq", 1'b0, irq)
      wr(8'h34, 32'h1);
      #1;
      `CHK("irq", 1'b1, irq)
      rd(8'h30, 32'h1);
      @(posedge clk);
      #1;
      `CHK("irq", 1'b0, irq)
      conclude();
   end
endmodule
`default_nettype wire
